// ### rst_pwr_consts.vh
/*
 * constants for the reset and power-down sequencer: register map,
 * reset values, state indicator codes and hold counts.
 * assumes a 100 MHz system clock and a single 32-bit AXI4-Lite slave.
 */
`ifndef RST_PWR_CONSTS_VH
`define RST_PWR_CONSTS_VH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define ADDR_MSTOP_CTRL 5'h00
`define ADDR_MSTOP_STATE 5'h04
`define ADDR_PWR_CTRL 5'h08
`define ADDR_PWR_STATUS 5'h0c
`define ADDR_WAKE_CODE 5'h10

// ****************************************************************
// reset values and fields
// ****************************************************************
`define MSTOP_RESET 32'h0000_0000
`define PWR_CTRL_RST_TYPE_BIT 0
`define PWR_CTRL_WDT_MODE_BIT 1
`define PWR_CTRL_RESET 2'h0
`define WAKE_NMI_CODE 12'h1c0
`define WAKE_IRL_BASE 12'h200
`define WAKE_MOD_CODE 12'h400

// ****************************************************************
// state indicator encodings {hi, lo}
// ****************************************************************
`define IND_NORMAL 2'h0
`define IND_RESET 2'h3
`define IND_SLEEP 2'h2

// ****************************************************************
// hold counts, in ticks of the respective clock enable; divider ratios in system clocks
// ****************************************************************
`define CRYSTAL_CLOCK_POR_HOLD 12'd20
`define CRYSTAL_CLOCK_WDT_SETUP 12'd1
`define CRYSTAL_CLOCK_WDT_HOLD 12'd3774
`define PCK_POR_HOLD 12'd45
`define PCK_WDT_SETUP 12'd5
`define CRYSTAL_CLOCK_DIV 4'd4
`define PCK_DIV 4'd2

`endif

// ### tick_div.v
/*
 * clock enable divider: one-cycle pulse every div_i cycles.
 * assumes a synchronous active-high reset on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tick_div (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [3:0] div_i,
  output reg tick_o
);
  reg [3:0] cnt;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt >= div_i - 4'h1) begin
      cnt <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rst_pwr_ctrl.v
/*
 * reset and power-down sequencer with module clock stop control and
 * an AXI4-Lite register slave.
 * assumes all pins are synchronous to clk_sys_i; crystal and peripheral
 * clock rates are modelled as enables from two dividers.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
// Operation
// - after power-on release, hold reset 20 crystal then 45 peripheral ticks.
// - power-on reset shows at once; normal shows on peripheral tick.
// - watchdog overflow enters reset after 1 crystal then 5 peripheral ticks.
// - watchdog power-on reset held 3774 crystal then 45 peripheral ticks.
// - watchdog manual reset held at least 3774 crystal ticks.
// - watchdog reset indicator changes happen on peripheral ticks.
// - sleep instruction halts the core keeping its registers.
// - peripherals and clock output keep running in sleep.
// - sleep shows indicator high bit 1, low bit 0.
// - NMI, level lines or module interrupts end sleep despite block bit.
// - wake by interrupt starts exception handling and loads event code.
// - power-on, watchdog power-on or manual reset ends sleep.
// - stop register is longword only; a 1 stops that module clock.
// - stopped modules keep registers and pins, resume unchanged.
// - clearing a stop bit restores clock and ends standby.
// - in RTC backup every module but the RTC stops and loses state.
// - watchdog overflow gives power-on if type bit 0, manual if 1.
`timescale 1ns/10ps
`default_nettype none
`include "rst_pwr_consts.vh"
module rst_pwr_ctrl (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire por_n_i,
  input wire wdt_overflow_i,
  input wire sleep_req_i,
  input wire nmi_i,
  input wire [7:0] interrupt_level_inputs_i,
  input wire module_irq_i,
  input wire rtc_backup_i,
  input wire [31:0] module_busy_i,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg cpu_reset_o,
  output reg manual_reset_o,
  output reg cpu_halt_o,
  output reg wake_exception_o,
  output reg [11:0] interrupt_event_code_o,
  output reg [31:0] module_clk_en_o,
  output reg module_reset_o,
  output reg state_indicator_hi_o,
  output reg state_indicator_lo_o,
  output wire external_clock_output_o
);

  // ****************************************************************
  // clock enables
  // ****************************************************************
  wire crystal_clock_tick;
  wire pck_tick;
  reg clk_out;

  tick_div u_crystal_clock (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .div_i(`CRYSTAL_CLOCK_DIV),
    .tick_o(crystal_clock_tick)
  );

  tick_div u_pck (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .div_i(`PCK_DIV),
    .tick_o(pck_tick)
  );

  // clock output toggles in every state, sleep included
  always @(posedge clk_sys_i) begin
    if (sys_rst_i)
      clk_out <= 1'b0;
    else if (pck_tick)
      clk_out <= ~clk_out;
  end
  assign external_clock_output_o = clk_out;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [31:0] mstop;
  reg [1:0] pwr_ctrl;
  reg [1:0] wake_cause;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  localparam ST_RUN = 8'h01;
  localparam ST_POR_X = 8'h02;
  localparam ST_POR_P = 8'h04;
  localparam ST_WSET_X = 8'h08;
  localparam ST_WSET_P = 8'h10;
  localparam ST_WHOLD_X = 8'h20;
  localparam ST_SLEEP = 8'h40;
  localparam ST_WAKE = 8'h80;

  reg [7:0] state;
  reg [7:0] next_state;
  reg [11:0] cnt;
  reg [11:0] next_cnt;
  reg wdt_manual;
  reg next_wdt_manual;
  reg por_prev;
  wire wake_irq = nmi_i | (|interrupt_level_inputs_i) | module_irq_i;
  wire wdt_rst_en = pwr_ctrl[`PWR_CTRL_WDT_MODE_BIT];

  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_wdt_manual = wdt_manual;
    case (state)
      ST_RUN, ST_SLEEP, ST_WAKE: begin
        if (state == ST_RUN && sleep_req_i)
          next_state = ST_SLEEP;
        // any interrupt ends sleep, exception block bit is not consulted
        if (state == ST_SLEEP && wake_irq)
          next_state = ST_WAKE;
        if (state == ST_WAKE && pck_tick)
          next_state = ST_RUN;
        if (wdt_overflow_i && wdt_rst_en) begin
          next_state = ST_WSET_X;
          next_cnt = 12'd0;
          next_wdt_manual = pwr_ctrl[`PWR_CTRL_RST_TYPE_BIT];
        end
      end
      ST_POR_X: begin
        // the 20-tick hold only starts once the pin has been released
        if (por_prev && crystal_clock_tick) begin
          if (cnt == `CRYSTAL_CLOCK_POR_HOLD - 12'd1) begin
            next_state = ST_POR_P;
            next_cnt = 12'd0;
          end else
            next_cnt = cnt + 12'd1;
        end
      end
      ST_POR_P: begin
        if (pck_tick) begin
          if (cnt == `PCK_POR_HOLD - 12'd1) begin
            next_state = ST_RUN;
            next_cnt = 12'd0;
          end else
            next_cnt = cnt + 12'd1;
        end
      end
      ST_WSET_X: begin
        if (crystal_clock_tick) begin
          next_state = ST_WSET_P;
          next_cnt = 12'd0;
        end
      end
      ST_WSET_P: begin
        if (pck_tick) begin
          if (cnt == `PCK_WDT_SETUP - 12'd1) begin
            next_state = ST_WHOLD_X;
            next_cnt = 12'd0;
          end else
            next_cnt = cnt + 12'd1;
        end
      end
      ST_WHOLD_X: begin
        if (crystal_clock_tick) begin
          if (cnt == `CRYSTAL_CLOCK_WDT_HOLD - 12'd1) begin
            next_cnt = 12'd0;
            // manual reset ends after the crystal hold alone
            next_state = wdt_manual ? ST_RUN : ST_POR_P;
          end else
            next_cnt = cnt + 12'd1;
        end
      end
      default: begin
        next_state = ST_POR_X;
        next_cnt = 12'd0;
      end
    endcase
    // pin reset overrides everything, including a pending wake
    if (!por_n_i) begin
      next_state = ST_POR_X;
      next_cnt = 12'd0;
      next_wdt_manual = 1'b0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= ST_POR_X;
      cnt <= 12'd0;
      wdt_manual <= 1'b0;
      por_prev <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wdt_manual <= next_wdt_manual;
      por_prev <= por_n_i;
    end
  end

  // ****************************************************************
  // outputs toward core, peripherals and pins
  // ****************************************************************
  wire in_reset = (state == ST_POR_X) | (state == ST_POR_P) |
    (state == ST_WHOLD_X);
  localparam [1:0] IND_RST = `IND_RESET;
  localparam [1:0] IND_SLP = `IND_SLEEP;
  localparam [1:0] IND_RUN = `IND_NORMAL;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cpu_reset_o <= 1'b1;
      manual_reset_o <= 1'b0;
      cpu_halt_o <= 1'b0;
      wake_exception_o <= 1'b0;
      interrupt_event_code_o <= 12'h000;
      wake_cause <= 2'h0;
      module_reset_o <= 1'b1;
      module_clk_en_o <= 32'h0000_0000;
      state_indicator_hi_o <= 1'b1;
      state_indicator_lo_o <= 1'b1;
    end else begin
      cpu_reset_o <= (next_state == ST_POR_X) | (next_state == ST_POR_P) |
        ((next_state == ST_WHOLD_X) & ~next_wdt_manual);
      manual_reset_o <= (next_state == ST_WHOLD_X) & next_wdt_manual;
      // the core is only gated; its register file is untouched
      cpu_halt_o <= (next_state == ST_SLEEP);
      wake_exception_o <= (state == ST_SLEEP) & (next_state == ST_WAKE);
      if (state == ST_SLEEP && next_state == ST_WAKE) begin
        if (nmi_i) begin
          interrupt_event_code_o <= `WAKE_NMI_CODE;
          wake_cause <= 2'h1;
        end else if (|interrupt_level_inputs_i) begin
          interrupt_event_code_o <= `WAKE_IRL_BASE |
            {4'h0, interrupt_level_inputs_i};
          wake_cause <= 2'h2;
        end else begin
          interrupt_event_code_o <= `WAKE_MOD_CODE;
          wake_cause <= 2'h3;
        end
      end
      // backup power-off clears every module except the RTC
      module_reset_o <= rtc_backup_i | (next_state == ST_POR_X) |
        (next_state == ST_POR_P);
      // a stopped module only loses its clock, so it resumes unchanged
      module_clk_en_o <= rtc_backup_i ? 32'h0000_0000 : ~mstop;
      // reset shows immediately when the pin drops
      if (!por_n_i) begin
        state_indicator_hi_o <= IND_RST[1];
        state_indicator_lo_o <= IND_RST[0];
      end else if (pck_tick) begin
        if (in_reset) begin
          state_indicator_hi_o <= IND_RST[1];
          state_indicator_lo_o <= IND_RST[0];
        end else if (state == ST_SLEEP) begin
          state_indicator_hi_o <= IND_SLP[1];
          state_indicator_lo_o <= IND_SLP[0];
        end else begin
          state_indicator_hi_o <= IND_RUN[1];
          state_indicator_lo_o <= IND_RUN[0];
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg aw_full;
  reg w_full;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  // partial-width writes are refused rather than merged
  wire full_word = (w_strb == 4'hf);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      mstop <= `MSTOP_RESET;
      pwr_ctrl <= `PWR_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h2;
        if (aw_addr == `ADDR_MSTOP_CTRL && full_word) begin
          mstop <= w_data;
          s_axi_bresp <= 2'h0;
        end else if (aw_addr == `ADDR_PWR_CTRL && full_word) begin
          pwr_ctrl <= w_data[1:0];
          s_axi_bresp <= 2'h0;
        end
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `ADDR_MSTOP_CTRL: s_axi_rdata <= mstop;
        `ADDR_MSTOP_STATE: s_axi_rdata <= ~module_clk_en_o;
        `ADDR_PWR_CTRL: s_axi_rdata <= {30'h0, pwr_ctrl};
        `ADDR_PWR_STATUS: s_axi_rdata <= {20'h0, wake_cause, state,
          state_indicator_hi_o, state_indicator_lo_o};
        `ADDR_WAKE_CODE: s_axi_rdata <= {20'h0, interrupt_event_code_o};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// ### rst_pwr_asserts.sv
/* port checker for the reset and power-down sequencer.
   assumes rst_pwr_ctrl ports, crystal tick every 4 clocks and
   peripheral tick every 2 clocks. */
`timescale 1ns/10ps
`default_nettype none
module rst_pwr_asserts (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic por_n_i,
  input wire logic wdt_overflow_i,
  input wire logic nmi_i,
  input wire logic [7:0] interrupt_level_inputs_i,
  input wire logic rtc_backup_i,
  input wire logic cpu_reset_o,
  input wire logic manual_reset_o,
  input wire logic cpu_halt_o,
  input wire logic wake_exception_o,
  input wire logic [11:0] interrupt_event_code_o,
  input wire logic [31:0] module_clk_en_o,
  input wire logic state_indicator_hi_o,
  input wire logic state_indicator_lo_o,
  input wire logic external_clock_output_o
);
  logic [15:0] por_cnt;
  logic [15:0] man_cnt;
  wire [1:0] ind = {state_indicator_hi_o, state_indicator_lo_o};
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ****************************************
  // hold counters, saturating so a stuck reset never wraps
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (sys_rst_i || !por_n_i || !cpu_reset_o) por_cnt <= 16'h0;
    else if (por_cnt != 16'hffff) por_cnt <= por_cnt + 16'h1;
    if (sys_rst_i || !manual_reset_o) man_cnt <= 16'h0;
    else if (man_cnt != 16'hffff) man_cnt <= man_cnt + 16'h1;
  end
  sequence s_quiet;
    (!cpu_reset_o && !manual_reset_o) [*8];
  endsequence
  sequence s_unhalt;
    ##[0:1] !cpu_halt_o;
  endsequence
  AST_POR_IND: assert property (!por_n_i |=> ind == 2'h3)
    else $error("indicator not reset");
  AST_POR_HOLD: assert property ($fell(cpu_reset_o) |-> por_cnt >= 16'd160)
    else $error("power-on hold too short");
  AST_WDT_SETUP: assert property (
    wdt_overflow_i && !cpu_reset_o && !manual_reset_o |=> s_quiet)
    else $error("watchdog setup too short");
  AST_MAN_HOLD: assert property (
    $fell(manual_reset_o) |-> man_cnt >= 16'd15090)
    else $error("manual hold too short");
  AST_IND_TICK: assert property (
    $changed(ind) && por_n_i && $past(por_n_i)
    |-> $changed(external_clock_output_o))
    else $error("indicator off peripheral tick");
  AST_EXTERNAL_CLOCK_OUTPUT: assert property (
    $changed(external_clock_output_o) |=> $stable(external_clock_output_o))
    else $error("clock output too fast");
  AST_SLEEP_IND: assert property ($rose(cpu_halt_o) |-> ##[1:3] ind == 2'h2)
    else $error("sleep indicator missing");
  AST_NMI_WAKE: assert property (
    cpu_halt_o && $rose(nmi_i)
    |-> ##[1:2] wake_exception_o && interrupt_event_code_o == 12'h1c0)
    else $error("nmi wake wrong");
  AST_LVL_WAKE: assert property (
    cpu_halt_o && !nmi_i && $rose(|interrupt_level_inputs_i)
    |-> ##[1:2] wake_exception_o && interrupt_event_code_o[11:8] == 4'h2)
    else $error("level wake wrong");
  AST_WAKE_NORM: assert property (
    wake_exception_o |-> s_unhalt ##[0:2] ind == 2'h0)
    else $error("wake indicator wrong");
  AST_BACKUP: assert property (
    rtc_backup_i |-> ##1 module_clk_en_o == 32'h0)
    else $error("backup clocks running");
endmodule
bind rst_pwr_ctrl rst_pwr_asserts rst_pwr_asserts_inst (.clk_sys_i,
  .sys_rst_i, .por_n_i, .wdt_overflow_i, .nmi_i,
  .interrupt_level_inputs_i, .rtc_backup_i, .cpu_reset_o,
  .manual_reset_o, .cpu_halt_o, .wake_exception_o,
  .interrupt_event_code_o, .module_clk_en_o, .state_indicator_hi_o,
  .state_indicator_lo_o, .external_clock_output_o);
`default_nettype wire

// ### cpu_periph_model.sv
/* stand-in for one on-chip peripheral fed by a module clock enable.
   assumes module reset and clock enable come from the sequencer. */
`timescale 1ns/10ps
`default_nettype none
module cpu_periph_model (
  input wire logic clk_sys_i,
  input wire logic module_reset_i,
  input wire logic clk_en_i,
  input wire logic irq_req_i,
  output logic [7:0] count_o,
  output logic module_irq_o
);
  // ****************************************
  // counter that only advances while clocked
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (module_reset_i) count_o <= 8'h0;
    else if (clk_en_i) count_o <= count_o + 8'h1;
  end
  assign module_irq_o = irq_req_i;
endmodule
`default_nettype wire

// ### testbench.sv
/* self-checking bench for the reset and power-down sequencer.
   assumes the design's AXI4-Lite slave and a peripheral model. */
`timescale 1ns/10ps
`default_nettype none
`include "rst_pwr_consts.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, por_n_i = 1'b0;
  logic wdt_overflow_i = 1'b0, sleep_req_i = 1'b0, nmi_i = 1'b0;
  logic [7:0] interrupt_level_inputs_i = 8'h0;
  logic module_irq_i, rtc_backup_i = 1'b0, irq_req = 1'b0;
  logic [31:0] module_busy_i = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic cpu_reset_o, manual_reset_o, cpu_halt_o, wake_exception_o;
  logic [11:0] interrupt_event_code_o;
  logic [31:0] module_clk_en_o, rd;
  logic module_reset_o, state_indicator_hi_o, state_indicator_lo_o;
  logic external_clock_output_o;
  logic [7:0] count, c;
  int failures = 0, checked = 0, n, k;
  wire [1:0] ind = {state_indicator_hi_o, state_indicator_lo_o};
  typedef struct packed {
    logic [4:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] b;
    logic [31:0] r;
  } row_t;
  row_t rows [5] = '{'{5'h00, 32'h5, 4'hf, 2'h0, 32'h5},
    '{5'h00, 32'hffff0000, 4'h3, 2'h2, 32'h5},
    '{5'h04, 32'h1234, 4'hf, 2'h2, 32'h5},
    '{5'h00, 32'h0, 4'hf, 2'h0, 32'h0},
    '{5'h10, 32'h9, 4'hf, 2'h2, 32'h0}};
  logic [11:0] wake_exp [3] = '{12'h1c0, 12'h281, 12'h400};
  rst_pwr_ctrl rst_pwr_ctrl_inst (.clk_sys_i, .sys_rst_i, .por_n_i,
    .wdt_overflow_i, .sleep_req_i, .nmi_i, .interrupt_level_inputs_i,
    .module_irq_i, .rtc_backup_i, .module_busy_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_reset_o, .manual_reset_o, .cpu_halt_o, .wake_exception_o,
    .interrupt_event_code_o, .module_clk_en_o, .module_reset_o,
    .state_indicator_hi_o, .state_indicator_lo_o,
    .external_clock_output_o);
  cpu_periph_model cpu_periph_model_inst (.clk_sys_i,
    .module_reset_i(module_reset_o), .clk_en_i(module_clk_en_o[0]),
    .irq_req_i(irq_req), .count_o(count), .module_irq_o(module_irq_i));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************
  // bus and wait tasks
  // ****************************************
  task final_report;
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic waitc(input int w, input int lim, output int m);
    logic cnd;
    for (m = 0; m < lim; m++) begin
      @(posedge clk_sys_i);
      case (w)
        0: cnd = !cpu_reset_o;
        1: cnd = manual_reset_o;
        2: cnd = !manual_reset_o;
        3: cnd = cpu_reset_o;
        default: cnd = wake_exception_o;
      endcase
      if (cnd === 1'b1) break;
    end
    if (m == lim) begin
      failures++;
      final_report;
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    int i;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 100) waitc(5, 0, i);
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
    int i;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (i == 100) waitc(5, 0, i);
  endtask
  task sleep_now;
    sleep_req_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_req_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    por_n_i <= 1'b1;
    waitc(0, 400, n);
    `CHK("por_hold", 1'b1, n >= 160)
    repeat (4) @(posedge clk_sys_i);
    `CHK("ind_run", 2'h0, ind)
    axi_rd(`ADDR_MSTOP_CTRL, rd);
    `CHK("stop_rst", `MSTOP_RESET, rd)
    axi_rd(`ADDR_PWR_CTRL, rd);
    `CHK("pwr_rst", 32'h0, rd)
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d, rows[i].s, br);
      `CHK("bresp", rows[i].b, br)
      axi_rd(`ADDR_MSTOP_CTRL, rd);
      `CHK("stop", rows[i].r, rd)
      `CHK("clk_en", ~rows[i].r, module_clk_en_o)
    end
    axi_wr(`ADDR_MSTOP_CTRL, 32'h1, 4'hf, br);
    // the enable drops one edge after the store, so one last count lands
    @(posedge clk_sys_i);
    c = count;
    repeat (10) @(posedge clk_sys_i);
    `CHK("held", c, count)
    axi_wr(`ADDR_MSTOP_CTRL, 32'h0, 4'hf, br);
    repeat (4) @(posedge clk_sys_i);
    `CHK("resumed", 1'b1, count !== c)
    axi_wr(`ADDR_MSTOP_CTRL, 32'h0020_0000, 4'hf, br);
    repeat (2) axi_rd(`ADDR_MSTOP_STATE, rd);
    `CHK("stop_state", 32'h0020_0000, rd)
    `CHK("rresp", 2'h0, s_axi_rresp)
    for (k = 0; k < 3; k++) begin
      sleep_now;
      `CHK("halt", 1'b1, cpu_halt_o)
      `CHK("ind_sleep", 2'h2, ind)
      c = count;
      repeat (4) @(posedge clk_sys_i);
      `CHK("periph", 1'b1, count !== c)
      nmi_i <= (k == 0);
      interrupt_level_inputs_i <= (k == 1) ? 8'h81 : 8'h0;
      irq_req <= (k == 2);
      waitc(4, 20, n);
      `CHK("code", wake_exp[k], interrupt_event_code_o)
      nmi_i <= 1'b0;
      interrupt_level_inputs_i <= 8'h0;
      irq_req <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      `CHK("woke", 1'b0, cpu_halt_o)
      `CHK("ind_wake", 2'h0, ind)
      axi_rd(`ADDR_WAKE_CODE, rd);
      `CHK("code_reg", {20'h0, wake_exp[k]}, rd)
    end
    rtc_backup_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    `CHK("bk_clk", 32'h0, module_clk_en_o)
    `CHK("bk_rst", 1'b1, module_reset_o)
    rtc_backup_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    // manual type first, then power-on type taken from sleep
    axi_wr(`ADDR_PWR_CTRL, 32'h3, 4'hf, br);
    wdt_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b0;
    waitc(1, 40, n);
    `CHK("setup", 1'b1, n >= 8)
    `CHK("man_type", 1'b0, cpu_reset_o)
    waitc(2, 16000, n);
    `CHK("man_hold", 1'b1, n >= 15090)
    repeat (4) @(posedge clk_sys_i);
    `CHK("ind_man", 2'h0, ind)
    axi_wr(`ADDR_PWR_CTRL, 32'h2, 4'hf, br);
    sleep_now;
    wdt_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b0;
    waitc(3, 40, n);
    `CHK("wd_setup", 1'b1, n >= 8)
    waitc(0, 16000, n);
    `CHK("wd_hold", 1'b1, n >= 15090)
    repeat (4) @(posedge clk_sys_i);
    `CHK("wd_wake", 1'b0, cpu_halt_o)
    `CHK("ind_wd", 2'h0, ind)
    sleep_now;
    por_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    `CHK("ind_por", 2'h3, ind)
    repeat (20) @(posedge clk_sys_i);
    por_n_i <= 1'b1;
    waitc(0, 400, n);
    `CHK("por_hold2", 1'b1, n >= 160)
    repeat (4) @(posedge clk_sys_i);
    `CHK("por_wake", 1'b0, cpu_halt_o)
    final_report;
  end
endmodule
`default_nettype wire
